// ==== shared/dai_map.svh ====
// Offsets, field positions, reset values and timing counts of the
// display and aux I/O configuration bank. Definitions only.
`ifndef DAI_MAP_SVH
`define DAI_MAP_SVH

// Word addresses on the plain register port
`define DAI_ADDR_W 7
`define DAI_DATA_W 24
`define DAI_ADDR_SEG_LOW 7'h3d
`define DAI_ADDR_SEG_MID 7'h3e
`define DAI_ADDR_SEG_SPECIAL 7'h3f
`define DAI_ADDR_PUMP_CTRL 7'h40
`define DAI_ADDR_SERIAL_AUX 7'h41

// Segment image widths
`define DAI_SPECIAL_W 8
`define DAI_IMAGE_W 56

// Pump control word fields
`define DAI_DITHER_BIT 23
`define DAI_EXT_EN_BIT 22
`define DAI_RECHARGE_HI 21
`define DAI_RECHARGE_LO 20
`define DAI_DIRECT_BIT 19
`define DAI_OSC_SEL_BIT 18
`define DAI_DIAG_HI 3
`define DAI_DIAG_LO 0

// Serial and aux control word fields
`define DAI_RATE_HI 23
`define DAI_RATE_LO 21
`define DAI_BLINK_HI 20
`define DAI_BLINK_LO 17
`define DAI_DIV_OFS_HI 16
`define DAI_DIV_OFS_LO 11
`define DAI_GROUP_HI 10
`define DAI_GROUP_LO 8
`define DAI_AUX_VAL_HI 7
`define DAI_AUX_VAL_LO 6
`define DAI_AUX_B_DIR_HI 5
`define DAI_AUX_B_DIR_LO 4
`define DAI_AUX_A_DIR_HI 3
`define DAI_AUX_A_DIR_LO 2
`define DAI_KEY_SYNC_HI 1
`define DAI_KEY_SYNC_LO 0

// Reset values
`define DAI_SEG_RESET 24'h000000
`define DAI_CTRL_RESET 24'h000000

// Pump divider
`define DAI_PUMP_DIV_BASE 10'h1e0
`define DAI_CLK_HZ 125000000
`define DAI_PUMP_REF_HZ 4000000
`define DAI_PRESCALE (`DAI_CLK_HZ / `DAI_PUMP_REF_HZ)

// Diagnosis pin selections
`define DAI_DIAG_INTERNAL_LAST 4'hb
`define DAI_DIAG_IRQ 4'hc

// Serial master half period, from about 500 ns to about 10 us period
`define DAI_SPI_HALF_MIN_NS 250
`define DAI_SPI_HALF_MAX_NS 5000
`define DAI_CLK_NS 8
`define DAI_SPI_HALF_MIN ((`DAI_SPI_HALF_MIN_NS + `DAI_CLK_NS - 1) / `DAI_CLK_NS)
`define DAI_SPI_HALF_MAX (`DAI_SPI_HALF_MAX_NS / `DAI_CLK_NS)
`define DAI_SPI_HALF_STEP ((`DAI_SPI_HALF_MAX - `DAI_SPI_HALF_MIN) / 7)

// Blink timing in milliseconds
`define DAI_BLINK_P0_MS 11'd300
`define DAI_BLINK_P1_MS 11'd600
`define DAI_BLINK_P2_MS 11'd1000
`define DAI_BLINK_P3_MS 11'd2000
`define DAI_ON1_MS 11'd100
`define DAI_ON2_MS 11'd200
`define DAI_ON3_MS 11'd400
`define DAI_MS_NS 1000000
`define DAI_MS_CYCLES (`DAI_MS_NS / `DAI_CLK_NS)

// Display cycle length in clock cycles (20 ms)
`define DAI_FRAME_CYCLES 2500000

`endif

// ==== shared/dai_pkg.sv ====
// Types of the display and aux I/O configuration bank.
// Widths come from the map header.
`include "dai_map.svh"
package dai_pkg;

	typedef logic [`DAI_ADDR_W-1:0] dai_addr_type;
	typedef logic [`DAI_DATA_W-1:0] dai_data_type;

	typedef struct packed {
		dai_data_type segLow;
		dai_data_type segMid;
		logic [`DAI_SPECIAL_W-1:0] segSpecial;
		dai_data_type pumpCtrl;
		dai_data_type auxCtrl;
		logic nvPending;
		dai_data_type rdData;
		logic [4:0] prescale;
		logic [9:0] pumpCnt;
		logic [9:0] pumpDiv;
		logic [7:0] lfsr;
		logic pumpClk;
		logic [2:0] oscSync;
		logic oscLevel;
		logic [1:0][2:0] auxSync;
		logic [1:0] auxLevel;
		logic [1:0] auxOut;
		logic [1:0] auxOeN;
		logic [1:0] auxPullUp;
		logic [1:0] auxPullDown;
		logic [21:0] frameCnt;
		logic [1:0] rechCnt;
		logic recharge;
		logic [16:0] msCnt;
		logic [10:0] blinkMs;
		logic [`DAI_IMAGE_W-1:0] segOut;
		logic directDrive;
		logic spiBusy;
		logic [5:0] bitCnt;
		logic [`DAI_IMAGE_W-1:0] shift;
		logic [10:0] divCnt;
		logic [10:0] halfDiv;
		logic spiSck;
		logic spiSsnN;
		logic spiSdo;
		logic [2:0] groupEn;
		logic diagOut;
		logic diagOeN;
		logic [1:0] keySync;
	} dai_state_type;

endpackage

// ==== hdl/dai_config_regs.sv ====
// Display, charge pump, serial display master and aux I/O configuration bank.
// Assumes a processor on the same clock drives the plain register port and
// that pin inputs and the 10 kHz oscillator are asynchronous.
//
// Contract
// - Address 61 holds segment bits 23..0
// - Address 62 holds segment bits 47..24
// - Address 63 holds special segment bits 55..48
// - Segment registers never loaded from nonvolatile
// - Power-on copies nonvolatile words into 64, 65
// - Dither adds noise to pump divider
// - External enable selects serial master display
// - Recharge every (n+1)th display cycle
// - Direct drive bit selects supply voltage
// - Pump clock: oscillator or divided 4 MHz
// - Divider equals 480 plus offset field
// - Diagnosis pin: I/O, internal, interrupt
// - Rate field sets serial clock period
// - Blink upper bits set pulsing period
// - Blink lower bits set on-time
// - Group bits enable SCK, SSN, SDO pins
// - Aux value drives pins, reads back
// - First aux pin direction encoding
// - Second aux pin same encoding
// - Key sync speed field, exported as is
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`include "dai_map.svh"
module dai_config_regs #(
	parameter int unsigned MS_CYCLES = `DAI_MS_CYCLES,
	parameter int unsigned FRAME_CYCLES = `DAI_FRAME_CYCLES
) (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// Register port
	input wire dai_pkg::dai_addr_type addr,
	input wire dai_pkg::dai_data_type wrData,
	input wire logic wrEn,
	input wire logic rdEn,
	output dai_pkg::dai_data_type rdData,
	// Nonvolatile words loaded after reset
	input wire dai_pkg::dai_data_type nvPumpCtrl,
	input wire dai_pkg::dai_data_type nvSerialAux,
	// Charge pump
	input wire logic osc10k,
	output logic pumpClk,
	output logic recharge,
	output logic directDrive,
	// Integrated display image
	output logic [`DAI_IMAGE_W-1:0] segOut,
	// Serial display master
	output logic spiSck,
	output logic spiSsnN,
	output logic spiSdo,
	output logic [2:0] groupEn,
	// Aux pins
	input wire logic [1:0] auxPinIn,
	output logic [1:0] auxPinOut,
	output logic [1:0] auxPinOeN,
	output logic [1:0] auxPullUp,
	output logic [1:0] auxPullDown,
	// Diagnosis pin
	input wire logic multiIoIn,
	input wire logic [10:0] diagSrc,
	input wire logic irqIn,
	output logic diagOut,
	output logic diagOeN,
	// Key synchronisation speed
	output logic [1:0] keySync
);
	import dai_pkg::*;

	dai_state_type s;
	dai_state_type n;

	// Field views of the control words
	logic [1:0] rechSel;
	logic [3:0] diagSel;
	logic [2:0] rateSel;
	logic [1:0] periodSel;
	logic [1:0] onSel;
	logic [5:0] divOfs;
	logic [1:0] auxVal;
	logic [1:0][1:0] auxDir;
	logic [1:0] auxRead;
	logic [10:0] periodMs;
	logic [10:0] onMs;
	logic dispOn;
	logic tick4m;
	logic msTick;
	logic frameTick;
	logic [`DAI_IMAGE_W-1:0] image;

	// Fields are sliced from the stored words, not the bus, so a write
	// only reaches the logic one cycle after it lands
	// Blink nibble splits into period (upper) and on-time (lower)
	assign rechSel = s.pumpCtrl[`DAI_RECHARGE_HI:`DAI_RECHARGE_LO];
	assign diagSel = s.pumpCtrl[`DAI_DIAG_HI:`DAI_DIAG_LO];
	assign rateSel = s.auxCtrl[`DAI_RATE_HI:`DAI_RATE_LO];
	assign periodSel = s.auxCtrl[`DAI_BLINK_HI:`DAI_BLINK_HI-1];
	assign onSel = s.auxCtrl[`DAI_BLINK_LO+1:`DAI_BLINK_LO];
	assign divOfs = s.auxCtrl[`DAI_DIV_OFS_HI:`DAI_DIV_OFS_LO];
	assign auxVal = s.auxCtrl[`DAI_AUX_VAL_HI:`DAI_AUX_VAL_LO];
	assign auxDir[0] = s.auxCtrl[`DAI_AUX_A_DIR_HI:`DAI_AUX_A_DIR_LO];
	assign auxDir[1] = s.auxCtrl[`DAI_AUX_B_DIR_HI:`DAI_AUX_B_DIR_LO];
	assign image = {s.segSpecial, s.segMid, s.segLow};

	// Free running time bases
	// All three start together at reset and freeze together on ce,
	// so blink and display cycle ticks keep a fixed phase
	assign tick4m = (s.prescale == 5'(`DAI_PRESCALE - 1));
	assign msTick = (s.msCnt == 17'(MS_CYCLES - 1));
	assign frameTick = (s.frameCnt == 22'(FRAME_CYCLES - 1));

	// Per-pin readback: an output reads its own value, an input the pin
	generate
		for (genvar i = 0; i < 2; i++) begin : gAux
			assign auxRead[i] = (auxDir[i] == 2'h0) ? auxVal[i] : s.auxLevel[i];
		end
	endgenerate

	// Blink period and on-time decode
	always_comb begin
		unique case (periodSel)
			2'h0: periodMs = `DAI_BLINK_P0_MS;
			2'h1: periodMs = `DAI_BLINK_P1_MS;
			2'h2: periodMs = `DAI_BLINK_P2_MS;
			2'h3: periodMs = `DAI_BLINK_P3_MS;
		endcase
		unique case (onSel)
			2'h0: onMs = 11'h000;
			2'h1: onMs = `DAI_ON1_MS;
			2'h2: onMs = `DAI_ON2_MS;
			2'h3: onMs = `DAI_ON3_MS;
		endcase
		// Limitation: an on-time longer than the period keeps the display lit
		// Zero on-time means no pulsing, display stays lit
		dispOn = (onSel == 2'h0) || (s.blinkMs < onMs);
	end

	// Next state
	always_comb begin
		// Hold everything by default; read data stands for one cycle only,
		// so a stale answer can never be taken for a new one
		n = s;
		n.rdData = '0;

		// one-shot load of mirrored words after reset
		if (s.nvPending) begin
			n.pumpCtrl = nvPumpCtrl;
			n.auxCtrl = nvSerialAux;
			n.nvPending = 1'b0;
		end

		// Register writes; a bus write in the load cycle wins
		if (wrEn) begin
			unique case (addr)
				`DAI_ADDR_SEG_LOW: n.segLow = wrData;
				`DAI_ADDR_SEG_MID: n.segMid = wrData;
				`DAI_ADDR_SEG_SPECIAL: n.segSpecial = wrData[`DAI_SPECIAL_W-1:0];
				`DAI_ADDR_PUMP_CTRL: n.pumpCtrl = wrData;
				`DAI_ADDR_SERIAL_AUX: n.auxCtrl = wrData;
				default: begin
				end
			endcase
		end

		// Register reads, answered one cycle later
		if (rdEn) begin
			unique case (addr)
				`DAI_ADDR_SEG_LOW: n.rdData = s.segLow;
				`DAI_ADDR_SEG_MID: n.rdData = s.segMid;
				`DAI_ADDR_SEG_SPECIAL: n.rdData = {16'h0000, s.segSpecial};
				`DAI_ADDR_PUMP_CTRL: n.rdData = s.pumpCtrl;
				`DAI_ADDR_SERIAL_AUX: begin
					n.rdData = s.auxCtrl;
					n.rdData[`DAI_AUX_VAL_HI:`DAI_AUX_VAL_LO] = auxRead;
				end
				default: n.rdData = '0;
			endcase
		end

		// Oscillator and aux pin synchronisers, change once stages 2 and 3 agree
		// A level caught between stages is held, so a slow edge
		// never shows twice
		n.oscSync = {s.oscSync[1:0], osc10k};
		if (s.oscSync[2] == s.oscSync[1]) begin
			n.oscLevel = s.oscSync[2];
		end
		for (int i = 0; i < 2; i++) begin
			n.auxSync[i] = {s.auxSync[i][1:0], auxPinIn[i]};
			if (s.auxSync[i][2] == s.auxSync[i][1]) begin
				n.auxLevel[i] = s.auxSync[i][2];
			end
		end

		// 4 MHz reference prescaler
		n.prescale = tick4m ? 5'h00 : s.prescale + 5'h01;

		// The dither bit only ever lengthens a period by one reference tick
		// divider reloads only at wrap, so a new offset starts cleanly
		if (tick4m) begin
			if (s.pumpCnt >= s.pumpDiv - 10'h001) begin
				n.pumpCnt = 10'h000;
				n.pumpDiv = `DAI_PUMP_DIV_BASE + {4'h0, divOfs};
				n.lfsr = {s.lfsr[6:0], s.lfsr[7] ^ s.lfsr[5] ^ s.lfsr[4] ^ s.lfsr[3]};
				if (s.pumpCtrl[`DAI_DITHER_BIT]) begin
					n.pumpDiv = `DAI_PUMP_DIV_BASE + {4'h0, divOfs} + {9'h000, s.lfsr[0]};
				end
			end else begin
				n.pumpCnt = s.pumpCnt + 10'h001;
			end
		end

		// Pump clock is a registered compare, high for the first half of
		// each divided period, so it never glitches
		// pump clock source select
		if (s.pumpCtrl[`DAI_OSC_SEL_BIT]) begin
			n.pumpClk = s.oscLevel;
		end else begin
			n.pumpClk = (s.pumpCnt < {1'b0, s.pumpDiv[9:1]});
		end

		// Millisecond base and blink phase
		n.msCnt = msTick ? 17'h00000 : s.msCnt + 17'h00001;
		if (msTick) begin
			if (s.blinkMs >= periodMs - 11'h001) begin
				n.blinkMs = 11'h000;
			end else begin
				n.blinkMs = s.blinkMs + 11'h001;
			end
		end

		// Display cycle base
		n.frameCnt = frameTick ? 22'h000000 : s.frameCnt + 22'h000001;
		n.recharge = 1'b0;
		if (frameTick) begin
			if (s.rechCnt >= rechSel) begin
				n.rechCnt = 2'h0;
				n.recharge = 1'b1;
			end else begin
				n.rechCnt = s.rechCnt + 2'h1;
			end
			n.directDrive = s.pumpCtrl[`DAI_DIRECT_BIT];
			if (s.pumpCtrl[`DAI_EXT_EN_BIT] || !dispOn) begin
				n.segOut = '0;
			end else begin
				n.segOut = image;
			end
			// group enables follow at cycle start
			n.groupEn = s.pumpCtrl[`DAI_EXT_EN_BIT] ?
				s.auxCtrl[`DAI_GROUP_HI:`DAI_GROUP_LO] : 3'h0;
		end

		// Data changes on the falling serial clock and holds across the
		// rising one, where the far chip samples
		// start a serial frame in external mode
		if (frameTick && s.pumpCtrl[`DAI_EXT_EN_BIT] && !s.spiBusy) begin
			n.spiBusy = 1'b1;
			n.spiSsnN = 1'b0;
			n.spiSck = 1'b0;
			n.bitCnt = 6'(`DAI_IMAGE_W - 1);
			n.shift = dispOn ? image : '0;
			n.spiSdo = dispOn ? image[`DAI_IMAGE_W-1] : 1'b0;
			n.divCnt = 11'h000;
			n.halfDiv = 11'(`DAI_SPI_HALF_MIN) + 11'(`DAI_SPI_HALF_STEP) * {8'h00, rateSel};
		end else if (s.spiBusy) begin
			// running transfer keeps its own rate
			if (s.divCnt >= s.halfDiv - 11'h001) begin
				n.divCnt = 11'h000;
				if (!s.spiSck) begin
					n.spiSck = 1'b1;
				end else begin
					n.spiSck = 1'b0;
					if (s.bitCnt == 6'h00) begin
						n.spiBusy = 1'b0;
						n.spiSsnN = 1'b1;
						n.spiSdo = 1'b0;
					end else begin
						n.bitCnt = s.bitCnt - 6'h01;
						n.shift = {s.shift[`DAI_IMAGE_W-2:0], 1'b0};
						n.spiSdo = s.shift[`DAI_IMAGE_W-2];
					end
				end
			end else begin
				n.divCnt = s.divCnt + 11'h001;
			end
		end

		// Pulls follow the direction field only; a driven pin never has
		// a pull, so the pin cannot fight itself
		// Aux pins; output enable is low while driving
		for (int i = 0; i < 2; i++) begin
			n.auxOeN[i] = (auxDir[i] != 2'h0);
			n.auxPullUp[i] = (auxDir[i] == 2'h1);
			n.auxPullDown[i] = (auxDir[i] == 2'h2);
			n.auxOut[i] = auxVal[i];
		end

		// Codes above the interrupt select are undefined; the pin is
		// released rather than driven with a guess
		// diagnosis pin source
		n.diagOeN = 1'b0;
		if (diagSel == 4'h0) begin
			n.diagOut = multiIoIn;
		end else if (diagSel <= `DAI_DIAG_INTERNAL_LAST) begin
			n.diagOut = diagSrc[diagSel - 4'h1];
		end else if (diagSel == `DAI_DIAG_IRQ) begin
			n.diagOut = irqIn;
		end else begin
			n.diagOut = 1'b0;
			n.diagOeN = 1'b1;
		end

		n.keySync = s.auxCtrl[`DAI_KEY_SYNC_HI:`DAI_KEY_SYNC_LO];
	end

	// Reset assigns constants only; the stored words are copied on
	// the first enabled edge after release instead
	// State register; segment words clear at reset, never loaded
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.segLow <= `DAI_SEG_RESET;
			s.segMid <= `DAI_SEG_RESET;
			s.pumpCtrl <= `DAI_CTRL_RESET;
			s.auxCtrl <= `DAI_CTRL_RESET;
			s.nvPending <= 1'b1;
			s.pumpDiv <= `DAI_PUMP_DIV_BASE;
			s.lfsr <= 8'h01;
			s.spiSsnN <= 1'b1;
			s.auxOeN <= 2'h3;
			s.diagOeN <= 1'b1;
		end else if (ce) begin
			s <= n;
		end
	end

	// Outputs straight from the state register
	// No logic between these flops and the pins
	assign rdData = s.rdData;
	assign pumpClk = s.pumpClk;
	assign recharge = s.recharge;
	assign directDrive = s.directDrive;
	assign segOut = s.segOut;
	assign spiSck = s.spiSck;
	assign spiSsnN = s.spiSsnN;
	assign spiSdo = s.spiSdo;
	assign groupEn = s.groupEn;
	assign auxPinOut = s.auxOut;
	assign auxPinOeN = s.auxOeN;
	assign auxPullUp = s.auxPullUp;
	assign auxPullDown = s.auxPullDown;
	assign diagOut = s.diagOut;
	assign diagOeN = s.diagOeN;
	assign keySync = s.keySync;
endmodule

// ==== sim/dai_config_regs_sva.sv ====
// Port assertions for the display and aux I/O configuration bank.
// Assumes one clock domain; attached by the bind at the foot.
`timescale 1ns/10ps
`include "dai_map.svh"
module dai_config_regs_sva (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// Register port
	input wire logic rdEn,
	input wire dai_pkg::dai_data_type rdData,
	// Display and serial pins
	input wire logic recharge,
	input wire logic [`DAI_IMAGE_W-1:0] segOut,
	input wire logic spiSck,
	input wire logic spiSsnN,
	input wire logic spiSdo,
	// Aux pins
	input wire logic [1:0] auxPinOeN,
	input wire logic [1:0] auxPullUp,
	input wire logic [1:0] auxPullDown
);
	import dai_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// Frame opening: select falls, clock holds low for at least eight cycles
	sequence s_frame_open;
		$fell(spiSsnN);
	endsequence
	sequence s_sck_low;
		!spiSck [*8];
	endsequence
	a_frame_sck_low: assert property (s_frame_open |-> s_sck_low)
		else $error("serial clock rose too soon after select");
	a_sck_half_min: assert property ($rose(spiSck) |-> spiSck [*8])
		else $error("serial clock high phase too short");
	a_sck_in_frame: assert property (spiSck |-> !spiSsnN)
		else $error("serial clock pulsed outside a frame");
	a_sdo_hold_high: assert property (spiSck |-> $stable(spiSdo))
		else $error("serial data moved while clock high");
	a_ext_seg_blank: assert property (!spiSsnN |-> segOut == '0)
		else $error("integrated image driven during serial frame");
	a_rd_one_cycle: assert property (ce && !rdEn |=> rdData == '0)
		else $error("read data stood without a read");
	a_recharge_pulse: assert property (recharge |=> !recharge [*8])
		else $error("recharge pulses too close together");
	a_pull_excl_a: assert property (!(auxPullUp[0] && auxPullDown[0]))
		else $error("first aux pin has both pulls");
	a_drive_no_pull_a: assert property (!auxPinOeN[0] |-> !auxPullUp[0] && !auxPullDown[0])
		else $error("first aux pin pulled while driven");
	a_drive_no_pull_b: assert property (!auxPinOeN[1] |-> !auxPullUp[1] && !auxPullDown[1])
		else $error("second aux pin pulled while driven");
endmodule

bind dai_config_regs dai_config_regs_sva u_sva (.clock(clock), .rst(rst), .ce(ce),
	.rdEn(rdEn), .rdData(rdData), .recharge(recharge), .segOut(segOut), .spiSck(spiSck),
	.spiSsnN(spiSsnN), .spiSdo(spiSdo), .auxPinOeN(auxPinOeN), .auxPullUp(auxPullUp),
	.auxPullDown(auxPullDown));

// ==== sim/dai_ext_display.sv ====
// Model of the external display driver listening on the serial pins.
// Assumes the bank is the only master and sends MSB first.
`timescale 1ns/10ps
module dai_ext_display (
	// Serial pins
	input wire logic sck,
	input wire logic ssnN,
	input wire logic sdo,
	// Captured frame
	output logic [55:0] rxWord,
	output int rxCount
);
	initial begin
		rxWord = '0;
		rxCount = 0;
	end
	// Bit count restarts on select, so a short frame's count never adds to the last
	always @(negedge ssnN) begin
		rxCount = 0;
	end
	// Sample at the rising clock, as the far chip would
	always @(posedge sck) begin
		if (!ssnN) begin
			rxWord <= {rxWord[54:0], sdo};
			rxCount <= rxCount + 1;
		end
	end
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the configuration bank and its serial link.
// Assumes shortened display-cycle and millisecond counts.
`timescale 1ns/10ps
`include "dai_map.svh"
module tb_top;
	import dai_pkg::*;
	localparam int FRAME = 50;
	localparam int MS = 10;
	localparam int PDIV = (`DAI_PUMP_DIV_BASE + 32) * `DAI_PRESCALE;
	localparam logic [55:0] IMAGE = 56'h5a_abcdef_123456;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	dai_addr_type addr = '0;
	dai_data_type wrData = '0;
	logic wrEn = 1'b0;
	logic rdEn = 1'b0;
	dai_data_type rdData;
	dai_data_type nvPumpCtrl = 24'h00000c;
	dai_data_type nvSerialAux = 24'h000026;
	logic osc10k = 1'b0;
	logic [1:0] auxPinIn = 2'b11;
	logic multiIoIn = 1'b0;
	logic [10:0] diagSrc = 11'h010;
	logic irqIn = 1'b1;
	logic pumpClk, recharge, directDrive, spiSck, spiSsnN, spiSdo, diagOut, diagOeN;
	logic [55:0] segOut;
	logic [55:0] rxWord;
	logic [2:0] groupEn;
	logic [1:0] auxPinOut, auxPinOeN, auxPullUp, auxPullDown, keySync;
	int rxCount;
	int num_errors = 0;
	int num_checks = 0;

	// Bus clock and a slow free-running oscillator
	always #4 clock = ~clock;
	always #50000 osc10k = ~osc10k;

	dai_config_regs #(.MS_CYCLES(MS), .FRAME_CYCLES(FRAME)) uut (.clock, .rst, .ce, .addr,
		.wrData, .wrEn, .rdEn, .rdData, .nvPumpCtrl, .nvSerialAux, .osc10k, .pumpClk,
		.recharge, .directDrive, .segOut, .spiSck, .spiSsnN, .spiSdo, .groupEn, .auxPinIn,
		.auxPinOut, .auxPinOeN, .auxPullUp, .auxPullDown, .multiIoIn, .diagSrc, .irqIn,
		.diagOut, .diagOeN, .keySync);
	dai_ext_display u_disp (.sck(spiSck), .ssnN(spiSsnN), .sdo(spiSdo), .rxWord(rxWord),
		.rxCount(rxCount));

	task automatic check(string name, logic [55:0] exp, logic [55:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Bus cycles: one strobe cycle each, read data sampled mid next cycle
	task automatic wr(dai_addr_type a, dai_data_type d);
		@(posedge clock);
		addr <= a;
		wrData <= d;
		wrEn <= 1'b1;
		@(posedge clock);
		wrEn <= 1'b0;
	endtask
	task automatic rd(dai_addr_type a, dai_data_type exp, string name);
		@(posedge clock);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge clock);
		rdEn <= 1'b0;
		@(negedge clock);
		check(name, exp, rdData);
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Cycles from one rising pump clock to the next; a stall runs out the count
	task automatic pump_period(output int p);
		int k;
		k = 0;
		p = 0;
		while (pumpClk !== 1'b0 && k < 20000) begin
			@(negedge clock);
			k++;
		end
		while (pumpClk !== 1'b1 && k < 20000) begin
			@(negedge clock);
			k++;
		end
		while (pumpClk !== 1'b0 && p < 20000) begin
			@(negedge clock);
			p++;
		end
		while (pumpClk !== 1'b1 && p < 20000) begin
			@(negedge clock);
			p++;
		end
	endtask

	// Power-on copy, empty image, pin setup taken from stored words
	task automatic t_reset();
		rd(7'h40, 24'h00000c, "pump ctrl");
		rd(7'h41, 24'h0000e6, "serial aux");
		rd(7'h3d, 24'h000000, "seg low");
		check("pull up", 2'b01, auxPullUp);
		check("pull down", 2'b10, auxPullDown);
		check("aux oe", 2'b11, auxPinOeN);
		check("key sync", 2'b10, keySync);
		check("diag irq", 2'b01, {diagOeN, diagOut});
		@(posedge clock);
		irqIn <= 1'b0;
		repeat (3) @(negedge clock);
		check("diag irq low", 1'b0, diagOut);
	endtask
	// Image words, unmapped place, frozen strobe, then image on the pins
	task automatic t_seg();
		wr(7'h3d, 24'h123456);
		wr(7'h3e, 24'habcdef);
		wr(7'h3f, 24'hffff5a);
		wr(7'h42, 24'h777777);
		rd(7'h3e, 24'habcdef, "seg mid");
		rd(7'h3f, 24'h00005a, "seg special");
		rd(7'h42, 24'h000000, "unmapped");
		@(posedge clock);
		ce <= 1'b0;
		addr <= 7'h3d;
		wrData <= 24'h000000;
		wrEn <= 1'b1;
		@(posedge clock);
		ce <= 1'b1;
		wrEn <= 1'b0;
		rd(7'h3d, 24'h123456, "seg low");
		repeat (FRAME + 4) @(negedge clock);
		check("segment image", IMAGE, segOut);
	endtask
	// Driven pins read back the stored value; plain inputs drop pulls
	task automatic t_aux();
		wr(7'h41, 24'h000081);
		repeat (3) @(negedge clock);
		check("aux drive oe", 2'b00, auxPinOeN);
		check("aux drive val", 2'b10, auxPinOut);
		check("key sync", 2'b01, keySync);
		rd(7'h41, 24'h000081, "aux readback");
		wr(7'h41, 24'h00003c);
		repeat (3) @(negedge clock);
		check("plain input", 6'h30, {auxPinOeN, auxPullUp, auxPullDown});
	endtask
	// Diagnosis source table: pin, internal, interrupt, released
	task automatic t_diag();
		logic [3:0] sel [4] = '{4'h0, 4'h5, 4'hc, 4'hd};
		logic [1:0] exp [4] = '{2'b00, 2'b01, 2'b01, 2'b10};
		@(posedge clock);
		irqIn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(7'h40, {20'h0, sel[i]});
			repeat (3) @(negedge clock);
			check("diag pin", exp[i], {diagOeN, diagOeN ? 1'b0 : diagOut});
		end
	endtask
	// Divided pump period, dithered period, then the oscillator as source
	task automatic t_pump();
		int p;
		wr(7'h40, 24'h000000);
		wr(7'h41, 24'h010000);
		pump_period(p);
		check("pump period", PDIV, p);
		wr(7'h40, 24'h800000);
		pump_period(p);
		check("dither period", 1'b1, p == PDIV || p == PDIV + `DAI_PRESCALE);
		wr(7'h40, 24'h040000);
		@(osc10k);
		repeat (8) @(negedge clock);
		check("osc pump", osc10k, pumpClk);
	endtask
	// Shortest period with the shortest on-time, counted over one period
	task automatic t_blink();
		int lit;
		wr(7'h41, 24'h020000);
		repeat (FRAME + 2) @(negedge clock);
		lit = 0;
		for (int i = 0; i < 300 * MS; i++) begin
			@(negedge clock);
			if (segOut !== '0) begin
				lit++;
			end
		end
		check("blink on", 100 * MS, lit);
	endtask
	// External mode frame, group pins, direct drive, recharge spacing
	task automatic t_serial();
		int n;
		wr(7'h41, 24'h000700);
		wr(7'h40, 24'h780000);
		n = 0;
		while (!(rxCount == 56 && spiSsnN === 1'b1) && n < 6000) begin
			@(negedge clock);
			n++;
		end
		check("frame bits", 56, rxCount);
		check("frame closed", 1'b1, spiSsnN);
		check("serial frame", IMAGE, rxWord);
		check("groups", 3'b111, groupEn);
		check("ext blank", 56'h0, segOut);
		check("direct drive", 1'b1, directDrive);
		n = 0;
		while (recharge !== 1'b1 && n < 400) begin
			@(negedge clock);
			n++;
		end
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (recharge !== 1'b1 && n < 400);
		check("recharge gap", 4 * FRAME, n);
	endtask

	// Cut a hang short; the pump periods take most of the run
	initial begin
		repeat (90000) @(posedge clock);
		num_errors++;
		test_done();
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(negedge clock);
		t_reset();
		t_seg();
		t_aux();
		t_diag();
		t_pump();
		t_blink();
		t_serial();
		test_done();
	end
endmodule
